// [logic/mldc_ctrl.sv]
// Purpose: Loopback, FCS and full-duplex control between MAC core and pins
// Assumes: Pins are asynchronous and pass two flip-flops; core is on pclk
// Notes:   APB slave answers in the first access cycle
`include "mldc_params.svh"
// What this block does
// - Loopback happens only while the mode loop bit is one.
// - Serial internal loop: transmit feeds receive, serial pins idle, inputs ignored.
// - Serial external loop: transmit onto pins, receive from pins, collisions live.
// - MII internal loop bit loops the data port; management pins untouched.
// - Loop maps transmit nibble, clock and enable onto receive ones.
// - Loop carrier is transmit enable alone, masked by blinding; error line not looped.
// - Transmit pins keep toggling with real data during MII internal loop.
// - Padding and stripping act the same in loopback as normally.
// - Any loopback accepts runts internally; runt accept bit unchanged.
// - Receive status bit 27 flags an FCS error, loopback included.
// - Mode bit 3 set suppresses transmit FCS generation.
// - Loop bit with mode internal loop select and force bit forces a collision on every half-duplex attempt.
// - Reset gives MII; serial port select stops all MII activity.
// - Full duplex by enable bit, or MII autonegotiation when allowed.
// - Full duplex: transmit watermark alone requests transmit DMA.
// - Full duplex: receive DMA on watermark or any complete frame.
// - Full duplex: no defer on receive; gap starts at transmit end.
// - Full duplex: no blinding, SQE, collision or loss of carrier.
// - LED output is one in full duplex when its enable is set.
// - Outside loopback, short frames are discarded unless runts accepted.
module mldc_ctrl (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic [7:0]        paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              mii_tx_clk,
   input  wire logic              mii_rx_clk,
   input  wire mldc_pkg::mldc_nib_t mii_rxd,
   input  wire logic              mii_rx_dv,
   input  wire logic              mii_crs,
   input  wire logic              mii_col,
   output mldc_pkg::mldc_nib_t    mii_txd,
   output logic                   mii_tx_en,
   output logic                   mii_tx_er,
   input  wire logic              gps_rxd,
   output logic                   gps_txd,
   output logic                   gps_tx_en,
   input  wire mldc_pkg::mldc_nib_t core_txd,
   input  wire logic              core_tx_en,
   input  wire logic              core_tx_hold64,
   input  wire mldc_pkg::mldc_lvl_t core_tx_lvl,
   input  wire mldc_pkg::mldc_lvl_t core_rx_lvl,
   input  wire logic              core_rx_got64,
   input  wire logic              core_rx_done,
   input  wire logic              core_rx_short,
   input  wire logic              core_rx_fcs_bad,
   input  wire logic              an_full_duplex,
   output mldc_pkg::mldc_nib_t    lp_rxd,
   output logic                   lp_rx_dv,
   output logic                   lp_rx_strobe,
   output logic                   lp_crs,
   output logic                   lp_col,
   output logic                   fcs_gen_en,
   output logic                   runt_accept_eff,
   output logic                   full_duplex,
   output logic                   defer_rx,
   output logic                   ipg_start,
   output logic                   sqe_test_en,
   output logic                   loss_of_carrier_flag_report,
   output logic [3:0]             led_out,
   output logic                   tx_dma_req,
   output logic                   rx_dma_req,
   output logic [31:0]            rx_status_word,
   output logic                   rx_discard
);
   import mldc_pkg::*;

   // ----------------------------------------------------------------
   // Registers and decode
   // ----------------------------------------------------------------
   logic [31:0] mode_reg, cfg_reg, miictl_reg, fifo_reg;
   logic [3:0]  led_en_reg;
   logic        setup, wr_en;

   // Valid register address
   function automatic logic addr_hit(input logic [7:0] a);
      addr_hit = (a == `MLDC_OFS_MODE) || (a == `MLDC_OFS_CFG) ||
                 (a == `MLDC_OFS_MIICTL) || (a == `MLDC_OFS_FIFO) ||
                 (a == `MLDC_OFS_STAT) ||
                 (a[7:4] == 4'h1 && a[1:0] == 2'b00);
   endfunction : addr_hit

   // FIFO threshold from a two-bit watermark field
   function automatic mldc_lvl_t wm_level(input logic [1:0] w);
      wm_level = {2'b00, w, 4'b0000} + 8'h10;
   endfunction : wm_level

   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pready & pwrite & addr_hit(paddr);

   // Config registers, written on the access edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg   <= `MLDC_RST_MODE;
         cfg_reg    <= `MLDC_RST_CFG;
         miictl_reg <= `MLDC_RST_MIICTL;
         fifo_reg   <= `MLDC_RST_FIFO;
      end else if (wr_en) begin
         case (paddr)
            `MLDC_OFS_MODE:   mode_reg   <= pwdata;
            `MLDC_OFS_CFG:    cfg_reg    <= pwdata;
            `MLDC_OFS_MIICTL: miictl_reg <= pwdata;
            `MLDC_OFS_FIFO:   fifo_reg   <= pwdata;
            default: ;
         endcase
      end
   end

   // One enable per LED status register
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_led
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               led_en_reg[gi] <= 1'b0;
            end else if (wr_en && paddr == (`MLDC_OFS_LED0 + 8'(4 * gi))) begin
               led_en_reg[gi] <= pwdata[`MLDC_LED_FD_LINK_LED_ENABLE];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Effective modes
   // ----------------------------------------------------------------
   logic loop_on, gp_serial_port_sel, mii_act, mii_il, gps_il, int_any;
   logic fd, runt_ok, force_col;

   assign loop_on  = mode_reg[`MLDC_MODE_LOOP];
   assign gp_serial_port_sel = mode_reg[`MLDC_MODE_PS_LO +: 2] == `MLDC_PS_GP_SERIAL_PORT;
   assign mii_act  = ~gp_serial_port_sel;
   assign mii_il   = loop_on & mii_act & miictl_reg[`MLDC_MII_ILOOP];
   assign gps_il   = loop_on & gp_serial_port_sel & mode_reg[`MLDC_MODE_INTERNAL_LOOP_SELECT];
   assign int_any  = mii_il | gps_il;
   // Full duplex by enable or resolved autonegotiation
   assign fd = cfg_reg[`MLDC_CFG_FULL_DUPLEX_ENABLE] |
               (mii_act & cfg_reg[`MLDC_CFG_AUTO_PORT_SELECT] &
                ~miictl_reg[`MLDC_MII_ANDIS] & an_full_duplex);
   assign runt_ok = loop_on | cfg_reg[`MLDC_CFG_RPA] | fd;
   assign force_col = loop_on & mode_reg[`MLDC_MODE_INTERNAL_LOOP_SELECT] &
                      mode_reg[`MLDC_MODE_FORCE_COLLISION] & core_tx_en;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   localparam int NS = 10;
   logic [NS-1:0] pin_raw, pin_s1, pin_s2;
   logic          txc_d, rxc_d;
   assign pin_raw = {mii_tx_clk, mii_rx_clk, mii_rxd, mii_rx_dv,
                     mii_crs, mii_col, gps_rxd};

   // Two flops per pin
   generate
      for (gi = 0; gi < NS; gi++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_s1[gi] <= 1'b0;
               pin_s2[gi] <= 1'b0;
            end else begin
               pin_s1[gi] <= pin_raw[gi];
               pin_s2[gi] <= pin_s1[gi];
            end
         end
      end
   endgenerate

   logic      txc_s, rxc_s, dv_s, crs_s, col_s, grx_s;
   mldc_nib_t rxd_s;
   assign {txc_s, rxc_s, rxd_s, dv_s, crs_s, col_s, grx_s} = pin_s2;

   // Clock edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txc_d <= 1'b0;
         rxc_d <= 1'b0;
      end else begin
         txc_d <= txc_s;
         rxc_d <= rxc_s;
      end
   end

   // ----------------------------------------------------------------
   // Pin outputs
   // ----------------------------------------------------------------
   // MII drives only while selected, even in its own loop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mii_txd   <= 4'h0;
         mii_tx_en <= 1'b0;
         mii_tx_er <= 1'b0;
         gps_txd   <= 1'b0;
         gps_tx_en <= 1'b0;
      end else begin
         mii_txd   <= mii_act ? core_txd : 4'h0;
         mii_tx_en <= mii_act & core_tx_en;
         mii_tx_er <= 1'b0;
         gps_txd   <= gp_serial_port_sel & ~gps_il & core_txd[0];
         gps_tx_en <= gp_serial_port_sel & ~gps_il & core_tx_en;
      end
   end

   // ----------------------------------------------------------------
   // Receive path to the core
   // ----------------------------------------------------------------
   logic crs_raw, blind;
   mldc_blind_t bl_state;
   logic [7:0]  bl_cnt;
   assign crs_raw = int_any ? core_tx_en : crs_s;

   // Loop or pin data into the core, same framing as normal
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lp_rxd       <= 4'h0;
         lp_rx_dv     <= 1'b0;
         lp_rx_strobe <= 1'b0;
         lp_crs       <= 1'b0;
         lp_col       <= 1'b0;
      end else begin
         if (int_any) begin
            lp_rxd       <= core_txd;
            lp_rx_dv     <= core_tx_en;
            lp_rx_strobe <= txc_s & ~txc_d;
         end else if (gp_serial_port_sel) begin
            lp_rxd       <= {3'b000, grx_s};
            lp_rx_dv     <= crs_s;
            lp_rx_strobe <= rxc_s & ~rxc_d;
         end else begin
            lp_rxd       <= rxd_s;
            lp_rx_dv     <= dv_s;
            lp_rx_strobe <= rxc_s & ~rxc_d;
         end
         lp_crs <= crs_raw & ~blind;
         lp_col <= ~fd & (force_col | (~int_any & col_s));
      end
   end

   // ----------------------------------------------------------------
   // Post-transmit blinding and SQE window
   // ----------------------------------------------------------------
   logic tx_en_d, tx_end, act_d, crs_seen;
   assign tx_end = tx_en_d & ~core_tx_en;
   assign blind  = bl_state == BL_BLIND;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bl_state <= BL_IDLE;
         bl_cnt   <= 8'h00;
      end else begin
         case (bl_state)
            BL_IDLE: begin
               bl_cnt <= 8'h00;
               if (tx_end && !fd) begin
                  bl_state <= BL_BLIND;
               end
            end
            BL_BLIND: begin
               bl_cnt <= bl_cnt + 8'h01;
               if (fd || bl_cnt == 8'(`MLDC_BLIND_CYC - 1)) begin
                  bl_state <= BL_IDLE;
               end
            end
            default: bl_state <= BL_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // MAC control outputs
   // ----------------------------------------------------------------
   // Activity history for gap and carrier checks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_en_d  <= 1'b0;
         act_d    <= 1'b0;
         crs_seen <= 1'b0;
      end else begin
         tx_en_d  <= core_tx_en;
         act_d    <= core_tx_en | crs_raw;
         crs_seen <= core_tx_en & (crs_seen | crs_raw);
      end
   end

   // Duplex dependent MAC behaviour
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fcs_gen_en      <= 1'b1;
         runt_accept_eff <= 1'b0;
         full_duplex     <= 1'b0;
         defer_rx        <= 1'b0;
         ipg_start       <= 1'b0;
         sqe_test_en     <= 1'b0;
         loss_of_carrier_flag_report     <= 1'b0;
         led_out         <= 4'h0;
      end else begin
         fcs_gen_en      <= ~mode_reg[`MLDC_MODE_FCSDIS];
         runt_accept_eff <= runt_ok;
         full_duplex     <= fd;
         defer_rx        <= ~fd & crs_raw;
         ipg_start       <= fd ? tx_end
                               : (act_d & ~(core_tx_en | crs_raw));
         sqe_test_en     <= blind;
         loss_of_carrier_flag_report     <= tx_end & ~fd & ~int_any & ~crs_seen;
         led_out         <= led_en_reg & {4{fd}};
      end
   end

   // ----------------------------------------------------------------
   // DMA requests and receive status
   // ----------------------------------------------------------------
   logic discard_now;
   assign discard_now = core_rx_done & core_rx_short & ~runt_ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_dma_req     <= 1'b0;
         rx_dma_req     <= 1'b0;
         rx_status_word <= 32'h0000_0000;
         rx_discard     <= 1'b0;
      end else begin
         tx_dma_req <= (core_tx_lvl >= wm_level(fifo_reg[`MLDC_FIFO_TXW_LO +: 2])) &
                       (fd | ~core_tx_hold64);
         rx_dma_req <= ((core_rx_lvl >= wm_level(fifo_reg[`MLDC_FIFO_RXW_LO +: 2])) &
                        (runt_ok | core_rx_got64)) |
                       (core_rx_done & ~discard_now);
         rx_discard <= discard_now;
         if (core_rx_done) begin
            rx_status_word <= 32'(core_rx_fcs_bad) << `MLDC_RX_FCS_BIT;
         end
      end
   end

   // ----------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         `MLDC_OFS_MODE:   rd_mux = mode_reg;
         `MLDC_OFS_CFG:    rd_mux = cfg_reg;
         `MLDC_OFS_MIICTL: rd_mux = miictl_reg;
         `MLDC_OFS_FIFO:   rd_mux = fifo_reg;
         `MLDC_OFS_STAT:   rd_mux = {26'h0, blind, mii_act, runt_ok,
                                     gps_il, mii_il, fd};
         default: begin
            if (paddr[7:4] == 4'h1 && paddr[1:0] == 2'b00) begin
               rd_mux[`MLDC_LED_FD_LINK_LED_ENABLE] = led_en_reg[paddr[3:2]];
            end
         end
      endcase
   end

   // Ready in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~addr_hit(paddr);
         prdata  <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   fcs_disable_a: assert property (wr_en && paddr == `MLDC_OFS_MODE && pwdata[3]
      |=> ##1 !fcs_gen_en) else $error("FCS not suppressed");
   loop_gate_a: assert property (!mode_reg[2] |-> !mii_il && !gps_il && !force_col)
      else $error("loop select active without loop bit");
   mii_loop_map_a: assert property (mii_il && $stable(mii_il)
      |=> lp_rxd == $past(core_txd) && lp_rx_dv == $past(core_tx_en))
      else $error("MII loop mapping wrong");
   tx_pins_live_a: assert property (mii_il |=> mii_tx_en == $past(core_tx_en))
      else $error("MII pins idle in loop");
   gp_serial_port_quiet_a: assert property (gps_il |=> !gps_tx_en && !gps_txd)
      else $error("serial outputs active in loop");
   mii_stop_a: assert property (gp_serial_port_sel |=> !mii_tx_en && mii_txd == 4'h0)
      else $error("MII driven in serial mode");
   fd_no_col_a: assert property (fd && $past(fd) |=> !lp_col && !loss_of_carrier_flag_report && !defer_rx)
      else $error("collision seen in full duplex");
   force_col_a: assert property (force_col && !fd |=> lp_col)
      else $error("forced collision missing");
   blind_len_a: assert property (blind && !fd
      |=> blind == ($past(bl_cnt) != 8'(`MLDC_BLIND_CYC - 1)))
      else $error("blinding window wrong length");
   led_fd_a: assert property (fd && led_en_reg[0] && $past(fd) && $past(led_en_reg[0])
      |-> led_out[0]) else $error("LED not lit in full duplex");
   runt_loop_a: assert property (loop_on && core_rx_done |=> !rx_discard)
      else $error("runt dropped in loopback");
   fcs_stat_a: assert property (core_rx_done |=> rx_status_word[27] == $past(core_rx_fcs_bad))
      else $error("FCS status bit wrong");

   mii_loop_c: cover property (mii_il && core_tx_en ##1 lp_rx_dv);
   fd_dma_c:   cover property (fd && core_rx_done ##1 rx_dma_req);
   discard_c:  cover property (discard_now ##1 rx_discard);
   blind_c:    cover property ($fell(blind));

endmodule : mldc_ctrl

// [logic/mldc_params.svh]
// Purpose: Offsets, fields, reset values and timing of the loopback/duplex block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef MLDC_PARAMS_SVH
`define MLDC_PARAMS_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define MLDC_OFS_MODE    8'h00
`define MLDC_OFS_CFG     8'h04
`define MLDC_OFS_MIICTL  8'h08
`define MLDC_OFS_FIFO    8'h0C
`define MLDC_OFS_LED0    8'h10
`define MLDC_OFS_STAT    8'h20
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MLDC_MODE_LOOP   2
`define MLDC_MODE_FCSDIS 3
`define MLDC_MODE_FORCE_COLLISION  4
`define MLDC_MODE_INTERNAL_LOOP_SELECT   6
`define MLDC_MODE_PS_LO  7
`define MLDC_CFG_FULL_DUPLEX_ENABLE    0
`define MLDC_CFG_AUTO_PORT_SELECT    1
`define MLDC_CFG_RPA     3
`define MLDC_MII_ILOOP   1
`define MLDC_MII_ANDIS   7
`define MLDC_FIFO_TXW_LO 8
`define MLDC_FIFO_RXW_LO 12
`define MLDC_LED_FD_LINK_LED_ENABLE   8
`define MLDC_RX_FCS_BIT  27
// ----------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------
`define MLDC_PS_GP_SERIAL_PORT     2'b10
`define MLDC_RST_MODE    32'h0000_0000
`define MLDC_RST_CFG     32'h0000_0002
`define MLDC_RST_MIICTL  32'h0000_0000
`define MLDC_RST_FIFO    32'h0000_0000
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MLDC_CLK_NS      25
`define MLDC_BLIND_NS    4000
`define MLDC_BLIND_CYC   (`MLDC_BLIND_NS / `MLDC_CLK_NS)
`endif

// [logic/mldc_pkg.sv]
// Purpose: Types shared by the loopback/duplex block
// Assumes: Constants come from mldc_params.svh
// Notes:   Types only
package mldc_pkg;
   typedef logic [3:0] mldc_nib_t;
   typedef logic [7:0] mldc_lvl_t;
   typedef enum logic {BL_IDLE, BL_BLIND} mldc_blind_t;
endpackage : mldc_pkg

// [tb/mldc_phy_model.sv]
// Purpose: PHY-side model of the MII and serial pins
// Assumes: PHY clocks free-run at 200 ns
// Notes:   Serial receive is wired back from serial transmit
module mldc_phy_model (
   output logic             tx_clk,
   output logic             rx_clk,
   output logic [3:0]       rxd,
   output logic             rx_dv,
   output logic             crs,
   output logic             col,
   output logic             ser_rxd,
   input  wire logic [3:0]  txd,
   input  wire logic        tx_en,
   input  wire logic        ser_txd,
   input  wire logic        phy_loop
);
   timeunit 1ns;
   timeprecision 100ps;
   // Transmit clock, receive clock out of phase
   initial begin
      tx_clk = 1'b0;
      rxd = 4'h0;
      rx_dv = 1'b0;
      forever #100 tx_clk = ~tx_clk;
   end
   assign rx_clk = ~tx_clk;
   // Echo only once the PHY is put in loop; idle data keeps changing
   always @(posedge tx_clk) begin
      rx_dv <= phy_loop & tx_en;
      rxd   <= (phy_loop & tx_en) ? txd : ~rxd;
   end
   assign crs = rx_dv;
   assign col = 1'b0;
   // Outside wiring for serial external loop
   assign ser_rxd = ser_txd;
endmodule : mldc_phy_model

// [tb/mldc_ctrl_tb.sv]
// Purpose: Self-checking bench of the loopback/duplex block
// Assumes: APB answers with pready; outputs checked at the falling edge
// Notes:   Table rows first, then hand-written cases
`include "mldc_params.svh"
module mldc_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import mldc_pkg::*;
   typedef struct {logic [31:0] mode; logic [31:0] cfg; logic [2:0] exp;} mldc_row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, phy_loop;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rx_status_word;
   logic mii_tx_clk, mii_rx_clk, mii_rx_dv, mii_crs, mii_col, mii_tx_en, mii_tx_er, gps_rxd, gps_txd, gps_tx_en;
   mldc_nib_t mii_rxd, mii_txd, core_txd, lp_rxd;
   mldc_lvl_t core_tx_lvl, core_rx_lvl;
   logic core_tx_en, core_tx_hold64, core_rx_got64, core_rx_done, core_rx_short, core_rx_fcs_bad;
   logic an_full_duplex, lp_rx_dv, lp_rx_strobe, lp_crs, lp_col, fcs_gen_en, runt_accept_eff, full_duplex;
   logic defer_rx, ipg_start, sqe_test_en, loss_of_carrier_flag_report, tx_dma_req, rx_dma_req, rx_discard;
   logic [3:0] led_out;
   int miscompares = 0;
   int comparisons = 0;
   mldc_row_t rows [5] = '{'{32'h0, 32'h2, 3'b100}, '{32'h8, 32'h2, 3'b000}, '{32'h4, 32'h2, 3'b110},
                           '{32'h0, 32'h3, 3'b111}, '{32'h0, 32'h0A, 3'b110}};
   mldc_ctrl i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .mii_tx_clk, .mii_rx_clk, .mii_rxd, .mii_rx_dv, .mii_crs, .mii_col, .mii_txd, .mii_tx_en, .mii_tx_er,
      .gps_rxd, .gps_txd, .gps_tx_en, .core_txd, .core_tx_en, .core_tx_hold64, .core_tx_lvl, .core_rx_lvl,
      .core_rx_got64, .core_rx_done, .core_rx_short, .core_rx_fcs_bad, .an_full_duplex, .lp_rxd, .lp_rx_dv,
      .lp_rx_strobe, .lp_crs, .lp_col, .fcs_gen_en, .runt_accept_eff, .full_duplex, .defer_rx, .ipg_start,
      .sqe_test_en, .loss_of_carrier_flag_report, .led_out, .tx_dma_req, .rx_dma_req, .rx_status_word, .rx_discard);
   mldc_phy_model i_phy (.tx_clk(mii_tx_clk), .rx_clk(mii_rx_clk), .rxd(mii_rxd), .rx_dv(mii_rx_dv),
      .crs(mii_crs), .col(mii_col), .ser_rxd(gps_rxd), .txd(mii_txd), .tx_en(mii_tx_en), .ser_txd(gps_txd),
      .phy_loop);
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic finish_test();
      if (miscompares == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // One APB transfer; holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [32:0] q);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         miscompares++;
         finish_test();
      end
      q = {pslverr, prdata};
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [32:0] q;
      apb(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [32:0] exp);
      logic [32:0] q;
      apb(1'b0, a, 32'h0000_0000, q);
      chk("apb read", q, exp);
   endtask : rd
   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask : settle
   task automatic tx(input logic en, input logic [3:0] d);
      @(posedge pclk);
      core_tx_en <= en;
      core_txd   <= d;
      settle(2);
   endtask : tx
   // Clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, phy_loop, an_full_duplex} = '0;
      {core_txd, core_tx_en, core_tx_hold64, core_tx_lvl, core_rx_lvl} = '0;
      {core_rx_got64, core_rx_done, core_rx_short, core_rx_fcs_bad} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      settle(0);
      chk("mii selected", {fcs_gen_en, gps_tx_en}, 2'b10);
      rd(`MLDC_OFS_CFG, {1'b0, `MLDC_RST_CFG});
      rd(8'h40, {1'b1, 32'h0000_0000});
      foreach (rows[i]) begin
         wr(`MLDC_OFS_MODE, rows[i].mode);
         wr(`MLDC_OFS_CFG, rows[i].cfg);
         settle(2);
         chk("fcs runt fd", {fcs_gen_en, runt_accept_eff, full_duplex}, rows[i].exp);
         rd(`MLDC_OFS_CFG, {1'b0, rows[i].cfg});
      end
      // MII internal loop in half duplex
      wr(`MLDC_OFS_MODE, 32'h0000_0004);
      wr(`MLDC_OFS_CFG, 32'h0000_0002);
      wr(`MLDC_OFS_MIICTL, 32'h0000_0002);
      tx(1'b1, 4'hA);
      chk("loop rx", {lp_rx_dv, lp_rxd, lp_crs}, 6'b1_1010_1);
      chk("defer rx", defer_rx, 1'b1);
      chk("tx pins", {mii_tx_en, mii_txd, mii_tx_er}, 6'b1_1010_0);
      tx(1'b0, 4'h0);
      chk("sqe half", sqe_test_en, 1'b1);
      // Full duplex: DMA by watermark alone, no SQE, LED on
      wr(`MLDC_OFS_MIICTL, 32'h0000_0000);
      wr(`MLDC_OFS_CFG, 32'h0000_0003);
      wr(`MLDC_OFS_LED0, 32'h0000_0100);
      core_tx_hold64 <= 1'b1;
      core_tx_lvl    <= 8'h20;
      tx(1'b1, 4'h5);
      tx(1'b0, 4'h0);
      chk("fd dma sqe led", {tx_dma_req, sqe_test_en, led_out[0]}, 3'b101);
      // Autonegotiation path, then disabled
      an_full_duplex <= 1'b1;
      wr(`MLDC_OFS_CFG, 32'h0000_0002);
      settle(2);
      chk("autoneg fd", full_duplex, 1'b1);
      wr(`MLDC_OFS_MIICTL, 32'h0000_0080);
      settle(2);
      chk("autoneg off", full_duplex, 1'b0);
      // External MII loop through the PHY
      phy_loop <= 1'b1;
      tx(1'b1, 4'h3);
      settle(14);
      chk("ext mii loop", {lp_rx_dv, lp_rxd}, 5'b1_0011);
      // Serial port: external loop, internal loop, selects without loop
      wr(`MLDC_OFS_MODE, 32'h0000_0104);
      tx(1'b1, 4'h1);
      chk("ser ext", {gps_tx_en, gps_txd, mii_tx_en}, 3'b110);
      wr(`MLDC_OFS_MODE, 32'h0000_0144);
      settle(2);
      chk("ser int", {gps_tx_en, gps_txd}, 2'b00);
      wr(`MLDC_OFS_MODE, 32'h0000_0150);
      settle(2);
      chk("no loop", {gps_tx_en, runt_accept_eff, lp_col}, 3'b100);
      // Short frame with FCS error outside loopback
      wr(`MLDC_OFS_MODE, 32'h0000_0000);
      @(posedge pclk);
      {core_tx_en, core_rx_done, core_rx_short, core_rx_fcs_bad} <= 4'b0111;
      @(posedge pclk);
      {core_rx_done, core_rx_short, core_rx_fcs_bad} <= 3'b000;
      @(negedge pclk);
      chk("discard fcs", {rx_discard, rx_status_word[`MLDC_RX_FCS_BIT], rx_dma_req}, 3'b110);
      finish_test();
   end
endmodule : mldc_ctrl_tb
